// ### rtl/dec_pkg.sv
// Shared constants and types for the dual event counter card logic
package dec_pkg;
   localparam int          NUM_CH     = 2;
   localparam int          CNT_W      = 32;
   localparam int          NUM_IN     = 16;
   localparam int          NUM_OUT    = 8;
   localparam int          ID_W       = 4;
   localparam int          SYNC_W     = NUM_IN + ID_W;

   // Counter pins share the isolated inputs
   localparam logic [1:0][3:0] CNT_PIN  = {4'h4, 4'h0};
   localparam logic [1:0][3:0] GATE_PIN = {4'h6, 4'h2};

   localparam logic [CNT_W-1:0]   COUNT_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0]   CNT_ONE     = 32'h0000_0001;
   localparam logic [CNT_W-1:0]   CNT_ZERO    = 32'h0000_0000;
   localparam logic [NUM_OUT-1:0] OUT_RESET   = 8'h00;
   localparam logic [ID_W-1:0]    ID_RESET    = 4'h0;
   localparam logic [NUM_IN-1:0]  IN_RESET    = 16'h0000;
   localparam logic [SYNC_W-1:0]  SYNC_RESET  = 20'h0_0000;

   typedef enum logic [1:0] {
      DEC_MODE_EVENT = 2'b00,
      DEC_MODE_FREQ  = 2'b01,
      DEC_MODE_WIDTH = 2'b10
   } dec_mode_t;
endpackage

// ### rtl/dec_sync_if.sv
// Carrier between the pin synchroniser and its user
`timescale 1ns/10ps
interface dec_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] filt;
   modport src (output raw, input filt);
   modport snk (input raw, output filt);
endinterface

// ### rtl/dec_sync.sv
// Three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/10ps
module dec_sync #(
   parameter int         W         = 1,
   parameter bit         USE_RESET = 1'b1
) (
   // Clock and reset
   input  wire logic     clk_in,
   input  wire logic     rst_n_in,
   // Pins in, clean levels out
   dec_sync_if.snk       sif
);
   import dec_pkg::*;

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] filt_q;
   logic [W-1:0] filt_d;

   // Level changes only once stages two and three agree
   function automatic logic [W-1:0] agree(input logic [W-1:0] a, input logic [W-1:0] b,
                                          input logic [W-1:0] old);
      agree = (~(a ^ b) & a) | ((a ^ b) & old);
   endfunction

   always_comb begin
      filt_d = agree(s2_q, s3_q, filt_q);
   end

   always_ff @(posedge clk_in) begin
      if (USE_RESET && !rst_n_in) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         filt_q <= '0;
      end else begin
         s1_q   <= sif.raw;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   assign sif.filt = filt_q;
endmodule

// ### rtl/dec_top.sv
// Dual event counter with isolated input/output, card identity and reset retain
`timescale 1ns/10ps
// Operation
// - Two channels: events, frequency, pulse width
// - Enabled match pulses when count reaches compare
// - Count keeps going, wraps to zero
// - Per channel rising or falling edge select
// - Card identity read from on-board switch
// - No address or interrupt jumpers; host enumerates address and interrupt
// - Retain jumper chooses default or held outputs
module dec_top (
   // Clock and reset
   input  wire logic                                   ref_clk_in,
   input  wire logic                                   rst_n_in,
   // Field pins and board straps
   input  wire logic [dec_pkg::NUM_IN-1:0]             isolated_input_in,
   input  wire logic [dec_pkg::ID_W-1:0]               card_identity_switch_in,
   input  wire logic                                   reset_retain_jumper_in,
   // Output latch write from host logic
   input  wire logic [dec_pkg::NUM_OUT-1:0]            output_data_in,
   input  wire logic                                   output_write_in,
   // Channel configuration
   input  wire dec_pkg::dec_mode_t [dec_pkg::NUM_CH-1:0] ch_mode_in,
   input  wire logic [dec_pkg::NUM_CH-1:0]             ch_run_in,
   input  wire logic [dec_pkg::NUM_CH-1:0]             ch_clear_in,
   input  wire logic [dec_pkg::NUM_CH-1:0]             ch_falling_edge_in,
   input  wire logic [dec_pkg::NUM_CH-1:0]             ch_gate_en_in,
   input  wire logic [dec_pkg::NUM_CH-1:0]             ch_match_en_in,
   input  wire logic [dec_pkg::NUM_CH-1:0][dec_pkg::CNT_W-1:0] ch_compare_in,
   input  wire logic [dec_pkg::NUM_CH-1:0][dec_pkg::CNT_W-1:0] ch_window_in,
   // Field outputs and board status
   output logic [dec_pkg::NUM_OUT-1:0]                 isolated_output_out,
   output logic [dec_pkg::NUM_IN-1:0]                  isolated_input_out,
   output logic [dec_pkg::ID_W-1:0]                    card_id_out,
   // Channel results
   output logic [dec_pkg::NUM_CH-1:0][dec_pkg::CNT_W-1:0] ch_count_out,
   output logic [dec_pkg::NUM_CH-1:0][dec_pkg::CNT_W-1:0] ch_measure_out,
   output logic [dec_pkg::NUM_CH-1:0]                  ch_measure_valid_out,
   output logic [dec_pkg::NUM_CH-1:0]                  ch_match_irq_out
);
   import dec_pkg::*;

   // Pin synchronisers
   dec_sync_if #(.W(SYNC_W)) pin_if ();
   dec_sync_if #(.W(1))      jmp_if ();

   assign pin_if.raw = {card_identity_switch_in, isolated_input_in};
   assign jmp_if.raw = reset_retain_jumper_in;

   dec_sync #(
      .W         (SYNC_W),
      .USE_RESET (1'b1)
   ) u_pin_sync (
      .clk_in    (ref_clk_in),
      .rst_n_in  (rst_n_in),
      .sif       (pin_if.snk)
   );

   // Jumper chain has no reset so its level is known while reset is held
   dec_sync #(
      .W         (1),
      .USE_RESET (1'b0)
   ) u_jmp_sync (
      .clk_in    (ref_clk_in),
      .rst_n_in  (rst_n_in),
      .sif       (jmp_if.snk)
   );

   logic [NUM_IN-1:0]  in_lvl;
   logic [ID_W-1:0]    sw_lvl;
   logic               retain_lvl;

   assign in_lvl     = pin_if.filt[NUM_IN-1:0];
   assign sw_lvl     = pin_if.filt[SYNC_W-1:NUM_IN];
   assign retain_lvl = jmp_if.filt[0];

   // Board status and output latch
   logic [NUM_OUT-1:0] out_q;
   logic [NUM_OUT-1:0] out_d;
   logic [NUM_IN-1:0]  inmir_q;
   logic [NUM_IN-1:0]  inmir_d;
   logic [ID_W-1:0]    id_q;
   logic [ID_W-1:0]    id_d;
   logic               armed_q;
   logic               armed_d;

   always_comb begin
      out_d   = output_write_in ? output_data_in : out_q;
      inmir_d = in_lvl;
      // Closed switch pulls low, so all-closed reads as the top identity
      id_d    = ~sw_lvl;
      armed_d = 1'b1;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         // Retain keeps what the field wiring last saw; an unsettled jumper loads defaults
         if (retain_lvl) begin
            out_q <= out_q;
         end else begin
            out_q <= OUT_RESET;
         end
         inmir_q <= IN_RESET;
         id_q    <= ID_RESET;
         armed_q <= 1'b0;
      end else begin
         out_q   <= out_d;
         inmir_q <= inmir_d;
         id_q    <= id_d;
         armed_q <= armed_d;
      end
   end

   // No address or interrupt strap exists; the host side assigns both
   assign isolated_output_out = out_q;
   assign isolated_input_out  = inmir_q;
   assign card_id_out         = id_q;

   // Counter channels
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic             lvl;
         logic             gate_lvl;
         logic             prev_q;
         logic [CNT_W-1:0] count_q;
         logic [CNT_W-1:0] count_d;
         logic [CNT_W-1:0] tmr_q;
         logic [CNT_W-1:0] tmr_d;
         logic [CNT_W-1:0] meas_q;
         logic [CNT_W-1:0] meas_d;
         logic             mvalid_q;
         logic             mvalid_d;
         logic             match_q;
         logic             match_d;
         logic             lead;
         logic             trail;
         logic             active;
         logic             gate_ok;
         logic [CNT_W-1:0] step;

         assign lvl      = in_lvl[CNT_PIN[g]];
         assign gate_lvl = in_lvl[GATE_PIN[g]];

         always_comb begin
            step     = CNT_ZERO;
            // Leading edge is the selected one, trailing is its opposite
            lead     = armed_q & (ch_falling_edge_in[g] ? (prev_q & ~lvl) : (~prev_q & lvl));
            trail    = armed_q & (ch_falling_edge_in[g] ? (~prev_q & lvl) : (prev_q & ~lvl));
            active   = armed_q & (ch_falling_edge_in[g] ? ~lvl : lvl);
            gate_ok  = ~ch_gate_en_in[g] | gate_lvl;
            count_d  = count_q;
            tmr_d    = tmr_q;
            meas_d   = meas_q;
            mvalid_d = 1'b0;
            if (ch_clear_in[g]) begin
               count_d = COUNT_RESET;
               tmr_d   = COUNT_RESET;
            end else if (ch_run_in[g]) begin
               case (ch_mode_in[g])
                  DEC_MODE_EVENT: begin
                     if (lead && gate_ok) begin
                        count_d = count_q + CNT_ONE;
                     end
                  end
                  DEC_MODE_FREQ: begin
                     step = count_q + ((lead && gate_ok) ? CNT_ONE : CNT_ZERO);
                     // Zero window never closes; software must load one
                     if ((ch_window_in[g] != CNT_ZERO) && (tmr_q + CNT_ONE == ch_window_in[g])) begin
                        meas_d   = step;
                        mvalid_d = 1'b1;
                        count_d  = COUNT_RESET;
                        tmr_d    = COUNT_RESET;
                     end else begin
                        count_d  = step;
                        tmr_d    = tmr_q + CNT_ONE;
                     end
                  end
                  DEC_MODE_WIDTH: begin
                     if (trail) begin
                        meas_d   = count_q;
                        mvalid_d = 1'b1;
                        count_d  = COUNT_RESET;
                     end else if (active && gate_ok) begin
                        count_d  = count_q + CNT_ONE;
                     end
                  end
                  default: begin
                     count_d = count_q;
                  end
               endcase
            end
            // Fires on arrival at the compare value, not while resting on it
            match_d = ch_match_en_in[g] & (count_d == ch_compare_in[g]) & (count_d != count_q);
         end

         always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
               prev_q   <= 1'b0;
               count_q  <= COUNT_RESET;
               tmr_q    <= COUNT_RESET;
               meas_q   <= COUNT_RESET;
               mvalid_q <= 1'b0;
               match_q  <= 1'b0;
            end else begin
               prev_q   <= lvl;
               count_q  <= count_d;
               tmr_q    <= tmr_d;
               meas_q   <= meas_d;
               mvalid_q <= mvalid_d;
               match_q  <= match_d;
            end
         end

         assign ch_count_out[g]         = count_q;
         assign ch_measure_out[g]       = meas_q;
         assign ch_measure_valid_out[g] = mvalid_q;
         assign ch_match_irq_out[g]     = match_q;
      end
   endgenerate
endmodule

// ### tb/dec_monitor.sv
// Port-level checks for the dual event counter
`timescale 1ns/10ps
module dec_monitor (
   // Clock and reset
   input wire logic                                        ref_clk_in,
   input wire logic                                        rst_n_in,
   // Watched inputs
   input wire logic [dec_pkg::NUM_OUT-1:0]                 output_data_in,
   input wire logic                                        output_write_in,
   input wire logic [dec_pkg::ID_W-1:0]                    card_identity_switch_in,
   input wire logic [dec_pkg::NUM_CH-1:0]                  ch_clear_in,
   input wire logic [dec_pkg::NUM_CH-1:0]                  ch_match_en_in,
   input wire logic [dec_pkg::NUM_CH-1:0][dec_pkg::CNT_W-1:0] ch_compare_in,
   // Watched outputs
   input wire logic [dec_pkg::NUM_OUT-1:0]                 isolated_output_out,
   input wire logic [dec_pkg::ID_W-1:0]                    card_id_out,
   input wire logic [dec_pkg::NUM_CH-1:0][dec_pkg::CNT_W-1:0] ch_count_out,
   input wire logic [dec_pkg::NUM_CH-1:0]                  ch_match_irq_out
);
   import dec_pkg::*;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   latch_write_a: assert property (
      output_write_in |=> isolated_output_out == $past(output_data_in)) else $error("latch mismatch");
   clear_zero_a: assert property (
      ch_clear_in[0] |=> ch_count_out[0] == CNT_ZERO) else $error("clear failed");
   step_zero_a: assert property (
      $changed(ch_count_out[0]) |-> ch_count_out[0] == CNT_ZERO
         || ch_count_out[0] == $past(ch_count_out[0]) + CNT_ONE) else $error("count jump ch0");
   step_one_a: assert property (
      $changed(ch_count_out[1]) |-> ch_count_out[1] == CNT_ZERO
         || ch_count_out[1] == $past(ch_count_out[1]) + CNT_ONE) else $error("count jump ch1");
   match_value_a: assert property (
      ch_match_irq_out[0] |-> ch_count_out[0] == $past(ch_compare_in[0])
         && $past(ch_match_en_in[0])) else $error("match wrong");
   match_once_a: assert property (
      ch_match_irq_out[1] |=> !ch_match_irq_out[1]) else $error("match not a pulse");
   match_change_a: assert property (
      ch_match_irq_out[1] |-> $changed(ch_count_out[1])) else $error("match without change");
   card_id_a: assert property (
      $stable(card_identity_switch_in)[*8] |-> card_id_out == ~card_identity_switch_in)
      else $error("identity wrong");
endmodule
bind dec_top dec_monitor dec_monitor_i (.ref_clk_in, .rst_n_in, .output_data_in, .output_write_in,
   .card_identity_switch_in, .ch_clear_in, .ch_match_en_in, .ch_compare_in, .isolated_output_out,
   .card_id_out, .ch_count_out, .ch_match_irq_out);

// ### tb/dec_host_model.sv
// Host-side writer for the output latch
`timescale 1ns/10ps
module dec_host_model (
   // Clock
   input  wire logic                         clk_in,
   // Request from bench
   input  wire logic                         wr_req_in,
   input  wire logic [dec_pkg::NUM_OUT-1:0]  wr_data_in,
   // Latch write toward the card
   output logic [dec_pkg::NUM_OUT-1:0]       output_data_out = 8'h00,
   output logic                              output_write_out = 1'b0
);
   import dec_pkg::*;
   // Idle data flips each cycle so stale data is never taken
   always @(posedge clk_in) begin
      output_write_out <= #1 wr_req_in;
      output_data_out  <= #1 wr_req_in ? wr_data_in : ~output_data_out;
   end
endmodule

// ### tb/dec_top_tb_top.sv
// Directed bench for the dual event counter
`timescale 1ns/10ps
module dec_top_tb_top;
   import dec_pkg::*;
   logic                         ref_clk_in = 1'b0, rst_n_in = 1'b0, reset_retain_jumper_in = 1'b0;
   logic [NUM_IN-1:0]            isolated_input_in = '0;
   logic [ID_W-1:0]              card_identity_switch_in = 4'hf;
   logic [NUM_OUT-1:0]           output_data_in, isolated_output_out, host_data = 8'h00;
   logic                         output_write_in, host_req = 1'b0;
   dec_mode_t [NUM_CH-1:0]       ch_mode_in = '{DEC_MODE_EVENT, DEC_MODE_EVENT};
   logic [NUM_CH-1:0]            ch_run_in = '0, ch_clear_in = '0, ch_falling_edge_in = '0;
   logic [NUM_CH-1:0]            ch_gate_en_in = '0, ch_match_en_in = '0;
   logic [NUM_CH-1:0]            ch_measure_valid_out, ch_match_irq_out;
   logic [NUM_CH-1:0][CNT_W-1:0] ch_compare_in = '0, ch_window_in = '0, ch_count_out, ch_measure_out;
   logic [NUM_IN-1:0]            isolated_input_out;
   logic [ID_W-1:0]              card_id_out;
   int                           bad_count = 0, comparisons = 0, m0 = 0, n;
   always #2.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (ch_match_irq_out[0] === 1'b1) m0++;
   dec_top dec_top_i (.ref_clk_in, .rst_n_in, .isolated_input_in, .card_identity_switch_in,
      .reset_retain_jumper_in, .output_data_in, .output_write_in, .ch_mode_in, .ch_run_in,
      .ch_clear_in, .ch_falling_edge_in, .ch_gate_en_in, .ch_match_en_in, .ch_compare_in,
      .ch_window_in, .isolated_output_out, .isolated_input_out, .card_id_out, .ch_count_out,
      .ch_measure_out, .ch_measure_valid_out, .ch_match_irq_out);
   dec_host_model dec_host_model_i (.clk_in(ref_clk_in), .wr_req_in(host_req), .wr_data_in(host_data),
      .output_data_out(output_data_in), .output_write_out(output_write_in));
   task automatic cyc(input int c);
      repeat (c) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic do_reset;
      rst_n_in = 1'b0;
      cyc(6);
      rst_n_in = 1'b1;
      cyc(2);
   endtask
   task automatic pulse(input int b);
      isolated_input_in[b] = 1'b1;
      cyc(8);
      isolated_input_in[b] = 1'b0;
      cyc(8);
   endtask
   task automatic clear_all;
      ch_clear_in = 2'b11;
      cyc(1);
      ch_clear_in = 2'b00;
      cyc(1);
   endtask
   task automatic id_check;
      logic [3:0] v [3] = '{4'hf, 4'ha, 4'h0};
      foreach (v[i]) begin
         card_identity_switch_in = v[i];
         cyc(10);
         chk(card_id_out, 4'hf ^ v[i]);
      end
   endtask
   task automatic wait_valid(input int c);
      n = 0;
      while (ch_measure_valid_out[c] !== 1'b1 && n < 120) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic event_rise;
      ch_compare_in[0] = 32'h0000_0003;
      ch_match_en_in[0] = 1'b1;
      ch_run_in[0] = 1'b1;
      clear_all();
      m0 = 0;
      repeat (3) pulse(0);
      chk(ch_count_out[0], 32'h0000_0003);
      chk(m0, 1);
      pulse(0);
      chk(ch_count_out[0], 32'h0000_0004);
   endtask
   task automatic fall_ch1;
      ch_falling_edge_in[1] = 1'b1;
      ch_compare_in[1] = 32'h0000_0002;
      ch_match_en_in[1] = 1'b1;
      ch_run_in[1] = 1'b1;
      repeat (2) pulse(4);
      chk(ch_count_out[1], 32'h0000_0002);
      chk(ch_count_out[0], 32'h0000_0004);
   endtask
   task automatic width_ch1;
      ch_mode_in[1] = DEC_MODE_WIDTH;
      ch_falling_edge_in[1] = 1'b0;
      clear_all();
      isolated_input_in[4] = 1'b1;
      cyc(30);
      isolated_input_in[4] = 1'b0;
      wait_valid(1);
      chk(ch_measure_out[1], 32'd30);
   endtask
   // Window of 100 clocks, gate open for the first window and shut for the second
   task automatic freq_ch0;
      ch_mode_in[0] = DEC_MODE_FREQ;
      ch_window_in[0] = 32'd100;
      ch_gate_en_in[0] = 1'b1;
      isolated_input_in[2] = 1'b1;
      clear_all();
      repeat (3) pulse(0);
      chk(isolated_input_out, 16'h0004);
      wait_valid(0);
      chk(ch_measure_out[0], 32'd3);
      isolated_input_in[2] = 1'b0;
      repeat (2) pulse(0);
      wait_valid(0);
      chk(ch_measure_out[0], 32'd0);
   endtask
   task automatic retain;
      reset_retain_jumper_in = 1'b1;
      host_data = 8'ha5;
      host_req = 1'b1;
      cyc(1);
      host_req = 1'b0;
      // Jumper chain needs four edges before reset may sample it
      cyc(4);
      chk(isolated_output_out, 8'ha5);
      do_reset();
      chk(isolated_output_out, 8'ha5);
      reset_retain_jumper_in = 1'b0;
      cyc(6);
      do_reset();
      chk(isolated_output_out, 8'h00);
   endtask
   initial begin
      cyc(4);
      rst_n_in = 1'b1;
      cyc(2);
      id_check();
      event_rise();
      fall_ch1();
      width_ch1();
      freq_ch0();
      retain();
      report_and_stop();
   end
   // Whole run is well under 1000 cycles
   initial begin
      #20000;
      bad_count++;
      report_and_stop();
   end
endmodule
